// *** src/serial_channel_command_and_mode.v ***
// command decoder and mode configuration of one serial channel
`default_nettype none
`include "serial_cmd_mode_consts.vh"
module serial_channel_command_and_mode (
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire [3:0]  i_address,
    input  wire        i_read,
    input  wire        i_write,
    input  wire [31:0] i_writedata,
    input  wire [3:0]  i_byteenable,
    output reg  [31:0] o_readdata,
    output reg         o_waitrequest,
    input  wire        i_txc,
    input  wire        i_rxc,
    input  wire        i_rxd,
    input  wire        i_tx_serial,
    input  wire        i_tx_enable,
    input  wire        i_rx_enable,
    input  wire        i_hunt,
    input  wire        i_sdlc_eof,
    input  wire        i_tx_underrun,
    input  wire        i_rx_fifo_nonempty,
    input  wire        i_rx_first_mode,
    input  wire        i_special_cond,
    input  wire        i_tx_load,
    input  wire        i_crc_done,
    output reg         o_txd,
    output reg         o_rx_serial,
    output reg         o_rx_clock_edge,
    output reg         o_tx_clock_edge,
    output reg  [1:0]  o_modem,
    output reg         o_chan_reset,
    output reg         o_rx_crc_reset,
    output reg         o_tx_crc_reset,
    output reg         o_crc_preset_ones,
    output reg         o_append_crc,
    output reg         o_tx_flush,
    output reg         o_ext_unlatch,
    output reg         o_rx_int_req,
    output reg         o_tx_int_clear,
    output reg         o_tx_int_suppress,
    output reg         o_error_reset,
    output reg         o_rx_hold,
    output reg         o_underrun_latch,
    output reg  [6:0]  o_clock_div,
    output reg         o_start_detect,
    output reg         o_sync_mode,
    output reg  [1:0]  o_sync_sel,
    output reg         o_sdlc,
    output reg  [2:0]  o_stop_halves,
    output reg         o_parity_en,
    output reg         o_parity_even,
    output reg         o_extra_bit
);
// ----------------------------------------
// states of the abort sender
// ----------------------------------------
localparam [1:0] AB_IDLE = 2'b01;
localparam [1:0] AB_SEND = 2'b10;
// ----------------------------------------
// declarations
// ----------------------------------------
reg  [7:0] mode_q;
reg  [7:0] mode_d;
reg        loop_q;
reg        loop_d;
reg  [1:0] modem_q;
reg  [1:0] modem_d;
reg        latch_d;
reg        rearm_q;
reg        rearm_d;
reg        suppress_d;
reg        hold_d;
reg  [1:0] ab_state_q;
reg  [1:0] ab_state_d;
reg  [3:0] ab_count_q;
reg  [3:0] ab_count_d;
reg        txc_s1_q;
reg        txc_s2_q;
reg        txc_prev_q;
reg        rxc_s1_q;
reg        rxc_s2_q;
reg        rxd_s1_q;
reg        rxd_s2_q;
reg        rclk_prev_q;
reg        rx_en_prev_q;
reg        hunt_prev_q;
wire       wr_acc;
wire       cmd_wr;
wire [1:0] crc_code;
wire [2:0] cmd_code;
wire       chan_rst;
wire       abort_cmd;
wire       is_sync;
wire       is_sdlc;
wire       append;
wire       rclk_sel;
wire       tx_edge;
wire       rearm_fire;
// ----------------------------------------
// helper functions
// ----------------------------------------
function [6:0] rate_div;
    input [1:0] rate;
    begin
        case (rate)
            `RATE_X1:  rate_div = `DIV_X1;
            `RATE_X16: rate_div = `DIV_X16;
            `RATE_X32: rate_div = `DIV_X32;
            default:   rate_div = `DIV_X64;
        endcase
    end
endfunction
function [2:0] stop_halves;
    input [1:0] stop;
    begin
        case (stop)
            `STOP_ONE:      stop_halves = `HALVES_ONE;
            `STOP_ONE_HALF: stop_halves = `HALVES_ONE_HALF;
            `STOP_TWO:      stop_halves = `HALVES_TWO;
            default:        stop_halves = 3'h0;
        endcase
    end
endfunction
function [31:0] reg_read;
    input [3:0] addr;
    input [7:0] mode;
    input       loop;
    input [4:0] stat;
    input [1:0] modem;
    begin
        case (addr)
            `OFS_COMMAND: reg_read = {31'h0, loop};
            `OFS_MODE:    reg_read = {24'h0, mode};
            `OFS_STATUS:  reg_read = {27'h0, stat};
            `OFS_MODEM:   reg_read = {30'h0, modem};
            default:      reg_read = 32'h0;
        endcase
    end
endfunction
// ----------------------------------------
// command decode
// ----------------------------------------
assign wr_acc    = i_write && !o_waitrequest;
assign cmd_wr    = wr_acc && i_byteenable[0] && (i_address == `OFS_COMMAND);
assign crc_code  = cmd_wr ? i_writedata[`CRC_HI:`CRC_LO] : `CRC_NULL;
assign cmd_code  = cmd_wr ? i_writedata[`CMD_HI:`CMD_LO] : `CMD_NULL;
assign chan_rst  = (cmd_code == `CMD_CHAN_RESET);
assign abort_cmd = (cmd_code == `CMD_ABORT);
assign is_sync   = (mode_q[`STOP_HI:`STOP_LO] == `STOP_SYNC);
assign is_sdlc   = is_sync && (mode_q[`SYNC_HI:`SYNC_LO] == `SYNC_SDLC);
assign append    = is_sync && i_tx_underrun && !o_underrun_latch;
assign rclk_sel  = loop_q ? txc_s2_q : rxc_s2_q;
assign tx_edge   = txc_s2_q && !txc_prev_q;
assign rearm_fire = rearm_q && i_rx_fifo_nonempty && !o_rx_hold;
// ----------------------------------------
// register and flag next values
// ----------------------------------------
always @* begin
    mode_d     = mode_q;
    loop_d     = loop_q;
    modem_d    = modem_q;
    latch_d    = o_underrun_latch;
    rearm_d    = rearm_q;
    suppress_d = o_tx_int_suppress;
    hold_d     = o_rx_hold;
    if (wr_acc && i_byteenable[0]) begin
        if (i_address == `OFS_MODE) mode_d = i_writedata[7:0];
        if (i_address == `OFS_MODEM) modem_d = i_writedata[1:0];
        if (i_address == `OFS_COMMAND) loop_d = i_writedata[`LOOP_BIT];
    end
    if ((crc_code == `CRC_EOM) && i_tx_enable) latch_d = 1'b0;
    if (abort_cmd || append) latch_d = 1'b1;
    if (rearm_fire) rearm_d = 1'b0;
    if (cmd_code == `CMD_REARM) rearm_d = 1'b1;
    if (i_tx_load || i_crc_done) suppress_d = 1'b0;
    if (cmd_code == `CMD_TXINT_RESET) suppress_d = 1'b1;
    if (cmd_code == `CMD_ERR_RESET) hold_d = 1'b0;
    if (i_rx_first_mode && i_special_cond) hold_d = 1'b1;
    if (chan_rst) begin
        mode_d     = `MODE_RESET_VAL;
        loop_d     = 1'b0;
        modem_d    = `MODEM_RESET_VAL;
        latch_d    = `LATCH_RESET_VAL;
        rearm_d    = 1'b0;
        suppress_d = 1'b0;
        hold_d     = 1'b0;
    end
end
// ----------------------------------------
// abort sender
// ----------------------------------------
always @* begin
    ab_state_d = ab_state_q;
    ab_count_d = ab_count_q;
    case (ab_state_q)
        AB_IDLE: begin
            if (abort_cmd && is_sdlc) begin
                ab_state_d = AB_SEND;
                ab_count_d = `ABORT_ONES;
            end
        end
        AB_SEND: begin
            if (chan_rst) begin
                ab_state_d = AB_IDLE;
                ab_count_d = 4'h0;
            end else if (tx_edge) begin
                ab_count_d = ab_count_q - 4'h1;
                if (ab_count_q == 4'h1) begin
                    ab_state_d = AB_IDLE;
                end
            end
        end
        default: begin
            ab_state_d = AB_IDLE;
            ab_count_d = 4'h0;
        end
    endcase
end
// ----------------------------------------
// pin synchronisers
// ----------------------------------------
always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        txc_s1_q    <= 1'b0;
        txc_s2_q    <= 1'b0;
        txc_prev_q  <= 1'b0;
        rxc_s1_q    <= 1'b0;
        rxc_s2_q    <= 1'b0;
        rxd_s1_q    <= 1'b1;
        rxd_s2_q    <= 1'b1;
        rclk_prev_q <= 1'b0;
    end else begin
        txc_s1_q    <= i_txc;
        txc_s2_q    <= txc_s1_q;
        txc_prev_q  <= txc_s2_q;
        rxc_s1_q    <= i_rxc;
        rxc_s2_q    <= rxc_s1_q;
        rxd_s1_q    <= i_rxd;
        rxd_s2_q    <= rxd_s1_q;
        rclk_prev_q <= rclk_sel;
    end
end
// ----------------------------------------
// state registers
// ----------------------------------------
always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        mode_q            <= `MODE_RESET_VAL;
        loop_q            <= 1'b0;
        modem_q           <= `MODEM_RESET_VAL;
        o_underrun_latch  <= `LATCH_RESET_VAL;
        rearm_q           <= 1'b0;
        o_tx_int_suppress <= 1'b0;
        o_rx_hold         <= 1'b0;
        ab_state_q        <= AB_IDLE;
        ab_count_q        <= 4'h0;
        rx_en_prev_q      <= 1'b0;
        hunt_prev_q       <= 1'b0;
    end else begin
        mode_q            <= mode_d;
        loop_q            <= loop_d;
        modem_q           <= modem_d;
        o_underrun_latch  <= latch_d;
        rearm_q           <= rearm_d;
        o_tx_int_suppress <= suppress_d;
        o_rx_hold         <= hold_d;
        ab_state_q        <= ab_state_d;
        ab_count_q        <= ab_count_d;
        rx_en_prev_q      <= i_rx_enable;
        hunt_prev_q       <= i_hunt;
    end
end
// ----------------------------------------
// registered outputs
// ----------------------------------------
always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        o_txd             <= 1'b1;
        o_rx_serial       <= 1'b1;
        o_rx_clock_edge   <= 1'b0;
        o_tx_clock_edge   <= 1'b0;
        o_modem           <= `MODEM_RESET_VAL;
        o_chan_reset      <= 1'b0;
        o_rx_crc_reset    <= 1'b0;
        o_tx_crc_reset    <= 1'b0;
        o_crc_preset_ones <= 1'b0;
        o_append_crc      <= 1'b0;
        o_tx_flush        <= 1'b0;
        o_ext_unlatch     <= 1'b0;
        o_rx_int_req      <= 1'b0;
        o_tx_int_clear    <= 1'b0;
        o_error_reset     <= 1'b0;
        o_clock_div       <= `DIV_X1;
        o_start_detect    <= 1'b0;
        o_sync_mode       <= 1'b1;
        o_sync_sel        <= 2'h0;
        o_sdlc            <= 1'b0;
        o_stop_halves     <= 3'h0;
        o_parity_en       <= 1'b0;
        o_parity_even     <= 1'b0;
        o_extra_bit       <= 1'b0;
    end else begin
        o_txd             <= (ab_state_q == AB_SEND) || !i_tx_enable || i_tx_serial;
        o_rx_serial       <= loop_q ? i_tx_serial : rxd_s2_q;
        o_rx_clock_edge   <= rclk_sel && !rclk_prev_q;
        o_tx_clock_edge   <= tx_edge;
        o_modem           <= modem_d;
        o_chan_reset      <= chan_rst;
        o_rx_crc_reset    <= (crc_code == `CRC_RX)
                             || (rx_en_prev_q && !i_rx_enable)
                             || (i_hunt && !hunt_prev_q)
                             || (is_sdlc && i_sdlc_eof);
        o_tx_crc_reset    <= (crc_code == `CRC_TX);
        o_crc_preset_ones <= is_sdlc;
        o_append_crc      <= append;
        o_tx_flush        <= abort_cmd;
        o_ext_unlatch     <= (cmd_code == `CMD_EXT_RESET);
        o_rx_int_req      <= rearm_fire;
        o_tx_int_clear    <= (cmd_code == `CMD_TXINT_RESET) || chan_rst;
        o_error_reset     <= (cmd_code == `CMD_ERR_RESET) || chan_rst;
        o_clock_div       <= rate_div(mode_d[`RATE_HI:`RATE_LO]);
        o_start_detect    <= (mode_d[`RATE_HI:`RATE_LO] != `RATE_X1);
        o_sync_mode       <= (mode_d[`STOP_HI:`STOP_LO] == `STOP_SYNC);
        o_sync_sel        <= (mode_d[`STOP_HI:`STOP_LO] == `STOP_SYNC)
                             ? mode_d[`SYNC_HI:`SYNC_LO] : 2'h0;
        o_sdlc            <= (mode_d[`STOP_HI:`STOP_LO] == `STOP_SYNC)
                             && (mode_d[`SYNC_HI:`SYNC_LO] == `SYNC_SDLC);
        o_stop_halves     <= stop_halves(mode_d[`STOP_HI:`STOP_LO]);
        o_parity_en       <= mode_d[`PAR_EN_BIT];
        o_parity_even     <= mode_d[`PAR_EN_BIT] && mode_d[`PAR_EVEN_BIT];
        o_extra_bit       <= mode_d[`PAR_EN_BIT];
    end
end
// ----------------------------------------
// avalon slave, one wait cycle per access
// ----------------------------------------
always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        o_waitrequest <= 1'b1;
        o_readdata    <= 32'h0;
    end else begin
        if ((i_read || i_write) && o_waitrequest) begin
            o_waitrequest <= 1'b0;
        end else begin
            o_waitrequest <= 1'b1;
        end
        if (i_read && o_waitrequest) begin
            o_readdata <= reg_read(i_address, mode_q, loop_q,
                                   {(ab_state_q == AB_SEND), o_rx_hold,
                                    o_tx_int_suppress, rearm_q, o_underrun_latch},
                                   modem_q);
        end
    end
end
endmodule
`default_nettype wire

// *** src/serial_cmd_mode_consts.vh ***
// constants for the serial channel command and mode block
`ifndef SERIAL_CMD_MODE_CONSTS_VH
`define SERIAL_CMD_MODE_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_COMMAND     4'h0
`define OFS_MODE        4'h4
`define OFS_STATUS      4'h8
`define OFS_MODEM       4'hC

// ----------------------------------------
// reset values
// ----------------------------------------
`define CMD_RESET_VAL   8'h00
`define MODE_RESET_VAL  8'h00
`define MODEM_RESET_VAL 2'h3
`define LATCH_RESET_VAL 1'h1

// ----------------------------------------
// command register fields and codes
// ----------------------------------------
`define CRC_HI          7
`define CRC_LO          6
`define CMD_HI          5
`define CMD_LO          3
`define LOOP_BIT        0
`define CRC_NULL        2'h0
`define CRC_RX          2'h1
`define CRC_TX          2'h2
`define CRC_EOM         2'h3
`define CMD_NULL        3'h0
`define CMD_ABORT       3'h1
`define CMD_EXT_RESET   3'h2
`define CMD_CHAN_RESET  3'h3
`define CMD_REARM       3'h4
`define CMD_TXINT_RESET 3'h5
`define CMD_ERR_RESET   3'h6
`define CMD_NULL7       3'h7

// ----------------------------------------
// mode register fields and codes
// ----------------------------------------
`define RATE_HI         7
`define RATE_LO         6
`define SYNC_HI         5
`define SYNC_LO         4
`define STOP_HI         3
`define STOP_LO         2
`define PAR_EVEN_BIT    1
`define PAR_EN_BIT      0
`define RATE_X1         2'h0
`define RATE_X16        2'h1
`define RATE_X32        2'h2
`define RATE_X64        2'h3
`define SYNC_SDLC       2'h2
`define STOP_SYNC       2'h0
`define STOP_ONE        2'h1
`define STOP_ONE_HALF   2'h2
`define STOP_TWO        2'h3
`define DIV_X1          7'h01
`define DIV_X16         7'h10
`define DIV_X32         7'h20
`define DIV_X64         7'h40
`define HALVES_ONE      3'h2
`define HALVES_ONE_HALF 3'h3
`define HALVES_TWO      3'h4

// ----------------------------------------
// timing
// ----------------------------------------
`define ABORT_ONES      4'h8

`endif

// *** testbench/serial_cmd_mode_sva.sv ***
// concurrent checks on the command and mode block ports
`default_nettype none
module serial_cmd_mode_checker (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic [3:0]  i_address,
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0]  i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic        o_waitrequest,
    input wire logic        i_tx_enable,
    input wire logic        o_txd,
    input wire logic        o_rx_crc_reset,
    input wire logic        o_tx_crc_reset,
    input wire logic        o_crc_preset_ones,
    input wire logic        o_sdlc,
    input wire logic        o_sync_mode,
    input wire logic [1:0]  o_sync_sel,
    input wire logic [2:0]  o_stop_halves,
    input wire logic [6:0]  o_clock_div,
    input wire logic        o_start_detect,
    input wire logic        o_parity_en,
    input wire logic        o_parity_even,
    input wire logic        o_extra_bit,
    input wire logic        o_tx_flush,
    input wire logic        o_underrun_latch,
    input wire logic        o_chan_reset,
    input wire logic [1:0]  o_modem
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire       acc = i_write && !o_waitrequest && i_address == 4'h0 && i_byteenable[0];
    wire [7:0] wd  = i_writedata[7:0];
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_rx_crc_code: assert property (acc && wd[7:6] == 2'h1 |-> ##[1:2] o_rx_crc_reset)
        else $error("receive crc reset missing");
    chk_tx_crc_code: assert property (acc && wd[7:6] == 2'h2 |-> ##[1:2] o_tx_crc_reset)
        else $error("transmit crc reset missing");
    chk_crc_preset: assert property ((o_rx_crc_reset || o_tx_crc_reset)
        |-> o_crc_preset_ones == o_sdlc)
        else $error("crc preset level wrong");
    chk_abort_flush: assert property (acc && wd[5:3] == 3'h1
        |-> ##[1:2] o_tx_flush ##[0:2] o_underrun_latch)
        else $error("abort flush or latch missing");
    chk_flush_once: assert property (o_tx_flush |=> !o_tx_flush)
        else $error("flush strobe longer than one cycle");
    chk_chan_modem: assert property (o_chan_reset |-> ##[0:2] o_modem == 2'h3)
        else $error("modem outputs not high after channel reset");
    chk_txd_mark: assert property (!$past(i_tx_enable) |-> o_txd)
        else $error("serial output not marking while disabled");
    chk_eom_ignored: assert property (acc && wd[7:6] == 2'h3 && !i_tx_enable
        && o_underrun_latch |=> o_underrun_latch [*3])
        else $error("latch cleared while transmitter disabled");
    chk_read_zero: assert property (i_read && !o_waitrequest && i_address == 4'h0
        |-> o_readdata[31:1] == 31'h0)
        else $error("command read shows nonzero bits");
    chk_sdlc_decode: assert property (o_sdlc == (o_sync_mode && o_sync_sel == 2'h2))
        else $error("sdlc decode wrong");
    chk_sync_stop: assert property (o_sync_mode == (o_stop_halves == 3'h0))
        else $error("stop field decode wrong");
    chk_start_det: assert property (o_start_detect == (o_clock_div != 7'h01))
        else $error("start detect not tied to ratio");
    chk_parity_bits: assert property (o_extra_bit == o_parity_en
        && !(o_parity_even && !o_parity_en))
        else $error("parity outputs inconsistent");
    cov_abort: cover property (o_tx_flush);
    cov_chan_reset: cover property (o_chan_reset);
    cov_sdlc_crc: cover property (o_rx_crc_reset && o_crc_preset_ones);
endmodule
bind serial_channel_command_and_mode serial_cmd_mode_checker u_chk (.i_clock, .i_rst,
    .i_address, .i_read, .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
    .i_tx_enable, .o_txd, .o_rx_crc_reset, .o_tx_crc_reset, .o_crc_preset_ones, .o_sdlc,
    .o_sync_mode, .o_sync_sel, .o_stop_halves, .o_clock_div, .o_start_detect, .o_parity_en,
    .o_parity_even, .o_extra_bit, .o_tx_flush, .o_underrun_latch, .o_chan_reset, .o_modem);
`default_nettype wire

// *** testbench/serial_link_station.sv ***
// remote station model driving shift clocks and receive data
`default_nettype none
module serial_link_station (
    input  wire logic       i_frame,
    input  wire logic [7:0] i_data,
    output logic            o_txc,
    output logic            o_rxc,
    output logic            o_rxd,
    output logic            o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_txc  = 1'b0;
        o_rxc  = 1'b0;
        o_rxd  = 1'b1;
        o_busy = 1'b0;
    end
    // clocks still and line marking outside frames; one rate both ways
    always @(posedge i_frame) begin
        o_busy = 1'b1;
        #3;
        for (int b = 0; b < 8; b++) begin
            o_rxd = i_data[b];
            #80 {o_txc, o_rxc} = 2'b11;
            #80 {o_txc, o_rxc} = 2'b00;
        end
        o_rxd  = 1'b1;
        o_busy = 1'b0;
    end
endmodule
`default_nettype wire

// *** testbench/serial_channel_command_and_mode_tb_top.sv ***
// self-checking bench of the command and mode block
`default_nettype none
module serial_channel_command_and_mode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_rst = 1, i_read = 0, i_write = 0, i_tx_serial = 0, i_tx_enable = 0;
    logic i_rx_enable = 1, i_hunt = 0, i_sdlc_eof = 0, i_tx_underrun = 0, i_special_cond = 0;
    logic i_rx_fifo_nonempty = 1, i_rx_first_mode = 1, i_tx_load = 0, i_crc_done = 0;
    logic        frame = 0;
    logic [7:0]  fdata = 8'h00;
    logic [3:0]  i_address = 4'h0, i_byteenable = 4'hF;
    logic [31:0] i_writedata = 32'h0, lfsr = 32'd99661, q;
    wire         i_txc, i_rxc, i_rxd, busy, o_waitrequest, o_txd, o_rx_serial, o_rx_clock_edge;
    wire         o_tx_clock_edge, o_chan_reset, o_rx_crc_reset, o_tx_crc_reset, o_crc_preset_ones;
    wire         o_append_crc, o_tx_flush, o_ext_unlatch, o_rx_int_req, o_tx_int_clear;
    wire         o_tx_int_suppress, o_error_reset, o_rx_hold, o_underrun_latch, o_start_detect;
    wire         o_sync_mode, o_sdlc, o_parity_en, o_parity_even, o_extra_bit;
    wire [31:0]  o_readdata;
    wire [1:0]   o_modem, o_sync_sel;
    wire [6:0]   o_clock_div;
    wire [2:0]   o_stop_halves;
    wire [8:0]   stb = {o_rx_crc_reset, o_tx_crc_reset, o_tx_flush, o_ext_unlatch, o_chan_reset,
                        o_tx_int_clear, o_error_reset, o_rx_int_req, o_append_crc};
    wire [17:0]  mobs = {o_clock_div, o_start_detect, o_sync_mode, o_sync_sel, o_sdlc,
                         o_stop_halves, o_parity_en, o_parity_even, o_extra_bit};
    int          failures = 0, num_checks = 0, cyc = 0, ne, nt;
    logic [8:0]  s;
    logic [7:0]  m, w;
    serial_channel_command_and_mode i_dut (.*);
    serial_link_station u_far (.i_frame(frame), .i_data(fdata), .o_txc(i_txc), .o_rxc(i_rxc),
                               .o_rxd(i_rxd), .o_busy(busy));
    always #4 i_clock = ~i_clock;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction
    function automatic logic [17:0] exp_mode(input logic [7:0] v);
        logic sm;
        sm = v[3:2] == 2'h0;
        return {7'h01 << (v[7:6] == 2'h0 ? 0 : v[7:6] + 3), v[7:6] != 2'h0, sm,
                sm ? v[5:4] : 2'h0, sm && v[5:4] == 2'h2, sm ? 3'h0 : {1'b0, v[3:2]} + 3'h1,
                v[0], v[0] & v[1], v[0]};
    endfunction
    function automatic logic [8:0] exp_stb(input logic [7:0] v);
        logic [2:0] c;
        c = v[5:3];
        return {v[7:6] == 2'h1, v[7:6] == 2'h2, c == 3'h1, c == 3'h2, c == 3'h3,
                c == 3'h5 || c == 3'h3, c == 3'h6 || c == 3'h3, c == 3'h4, 1'b0};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        i_address <= a;
        i_writedata <= {24'h0, d};
        i_write <= wr;
        i_read <= !wr;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic watch(input int n);
        s = 9'h0;
        repeat (n) begin
            @(posedge i_clock);
            s = s | stb;
        end
    endtask
    task automatic run_frame;
        int n;
        n = 0;
        ne = 0;
        nt = 0;
        fdata <= lfsr[7:0];
        frame <= 1'b1;
        @(posedge i_clock);
        frame <= 1'b0;
        while ((busy || n < 2) && n < 400) begin
            @(posedge i_clock);
            n++;
            ne += o_rx_clock_edge;
            nt += o_tx_clock_edge;
        end
        repeat (8) begin
            @(posedge i_clock);
            ne += o_rx_clock_edge;
            nt += o_tx_clock_edge;
        end
    endtask
    task automatic results;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        bus(0, 4'h0, 0); check(q, 32'h0);
        bus(0, 4'h4, 0); check(q, 32'h0);
        check({o_modem, o_underrun_latch}, 3'h7);
        bus(0, 4'h2, 0); check(q, 32'h0);
        for (int i = 0; i < 22; i++) begin
            lfsr = rnd(lfsr);
            m = i < 6 ? (i == 0 ? 8'h00 : i == 1 ? 8'hFF : i == 2 ? 8'h20 : i == 3 ? 8'h28 :
                i == 4 ? 8'h02 : 8'h43) : lfsr[7:0];
            if (m[7:6] == 2'h0 && m[3:2] == 2'h2) m[3:2] = 2'h3;
            bus(1, 4'h4, m);
            repeat (3) @(posedge i_clock);
            check(mobs, exp_mode(m));
            bus(0, 4'h4, 0); check(q, {24'h0, m});
        end
        i_byteenable <= 4'h0;
        bus(1, 4'h4, 8'h55);
        i_byteenable <= 4'hF;
        bus(0, 4'h4, 0); check(q, {24'h0, m});
        bus(1, 4'h4, 8'h00);
        for (int c = 0; c < 32; c++) begin
            w = {c[4:3], c[2:0], 3'h0};
            if (c[2:0] != 3'h3 || c[4:3] == 2'h0) begin
                bus(1, 4'h0, w);
                watch(6);
                check(s, exp_stb(w));
            end
        end
        bus(1, 4'h4, 8'h20);
        bus(1, 4'h0, 8'h40); watch(6); check({s[8], o_crc_preset_ones}, 2'h3);
        bus(1, 4'h0, 8'h80); watch(6); check({s[7], o_crc_preset_ones}, 2'h3);
        i_rx_enable <= 1'b0; watch(6); check(s[8], 1'b1);
        i_rx_enable <= 1'b1; i_hunt <= 1'b1; watch(6); check(s[8], 1'b1);
        i_hunt <= 1'b0; i_sdlc_eof <= 1'b1; @(posedge i_clock);
        i_sdlc_eof <= 1'b0; watch(6); check(s[8], 1'b1);
        bus(1, 4'h0, 8'hC0); watch(3); check(o_underrun_latch, 1'b1);
        i_tx_enable <= 1'b1;
        bus(1, 4'h0, 8'hC0); watch(3); check(o_underrun_latch, 1'b0);
        bus(1, 4'h4, 8'h00);
        i_tx_underrun <= 1'b1; @(posedge i_clock);
        i_tx_underrun <= 1'b0; watch(6); check({s[0], o_underrun_latch}, 2'h3);
        bus(1, 4'h4, 8'h20);
        bus(1, 4'h0, 8'h08); watch(6); check({o_txd, o_underrun_latch}, 2'h3);
        run_frame(); check(o_txd, 1'b0);
        check(nt, 8);
        bus(1, 4'h0, 8'h28); watch(3); check(o_tx_int_suppress, 1'b1);
        i_tx_load <= 1'b1; @(posedge i_clock);
        i_tx_load <= 1'b0; watch(3); check(o_tx_int_suppress, 1'b0);
        bus(1, 4'h0, 8'h28); i_crc_done <= 1'b1; @(posedge i_clock);
        i_crc_done <= 1'b0; watch(3); check(o_tx_int_suppress, 1'b0);
        i_special_cond <= 1'b1; @(posedge i_clock);
        i_special_cond <= 1'b0; watch(3); check(o_rx_hold, 1'b1);
        bus(1, 4'h0, 8'h30); watch(3); check(o_rx_hold, 1'b0);
        bus(1, 4'h0, 8'h01); bus(0, 4'h0, 0); check(q, 32'h1);
        i_tx_serial <= 1'b0; watch(4); check(o_rx_serial, 1'b0);
        lfsr = rnd(lfsr);
        run_frame(); check(ne, 8);
        bus(1, 4'h0, 8'h00); watch(6); check(o_rx_serial, 1'b1);
        bus(1, 4'h4, 8'hFF); bus(1, 4'hC, 8'h00); bus(1, 4'h0, 8'h01);
        bus(1, 4'h0, 8'h18); watch(4); check({s[4], o_modem}, 3'h7);
        bus(0, 4'h4, 0); check(q, 32'h0);
        bus(0, 4'h0, 0); check(q, 32'h0);
        results();
    end
endmodule
`default_nettype wire
